// >>> src/pirc_pkg.sv
// constants for the interrupt and charger register bank
package pirc_pkg;
    // register offsets
    localparam logic [7:0] OFS_IRQ_MASK_ONE = 8'h74;
    localparam logic [7:0] OFS_IRQ_MASK_TWO = 8'h75;
    localparam logic [7:0] OFS_IRQ_MASK_THREE = 8'h76;
    localparam logic [7:0] OFS_IRQ_STATUS_ONE = 8'h77;
    localparam logic [7:0] OFS_IRQ_STATUS_TWO = 8'h78;
    localparam logic [7:0] OFS_IRQ_STATUS_THREE = 8'h79;
    localparam logic [7:0] OFS_CHARGE_CONTROL_ONE = 8'h80;
    localparam logic [7:0] OFS_CHARGE_VOLTAGE_CONTROL = 8'h81;
    localparam logic [7:0] OFS_CHARGE_CURRENT_CONTROL = 8'h82;
    localparam logic [7:0] OFS_CHARGE_CONFIG = 8'h83;
    localparam logic [7:0] OFS_THERMISTOR_SUPERVISION = 8'h84;
    localparam logic [7:0] OFS_CHARGE_SUPERVISION = 8'h85;
    localparam logic [7:0] OFS_CHARGE_STATUS_ONE = 8'h86;
    localparam logic [7:0] OFS_CHARGE_LOCK = 8'h8e;
    // reset values
    localparam logic [7:0] RST_IRQ_MASK_ONE = 8'hff;
    localparam logic [7:0] RST_IRQ_MASK_TWO = 8'hff;
    localparam logic [2:0] RST_IRQ_MASK_THREE = 3'h7;
    localparam logic [7:0] RST_CHARGE_CONTROL_ONE = 8'hd1;
    localparam logic [7:0] RST_CHARGE_VOLTAGE_CONTROL = 8'h63;
    localparam logic [7:0] RST_CHARGE_CURRENT_CONTROL = 8'h41;
    localparam logic [6:0] RST_CHARGE_CONFIG = 7'h05;
    localparam logic [2:0] RST_THERMISTOR_SUPERVISION = 3'h0;
    localparam logic [5:0] RST_CHARGE_SUPERVISION = 6'h10;
    // field positions
    localparam int NOBAT_DET_BIT = 7;
    localparam int AUTO_RESUME_BIT = 6;
    localparam int CHARGE_ENABLE_BIT = 5;
    localparam int INPUT_CURRENT_LSB = 1;
    localparam int LIMITER_ENABLE_BIT = 0;
    localparam int RAIL_MIN_LSB = 6;
    localparam int EOC_CURRENT_HALF_BIT = 7;
    localparam int CC_LOW_RANGE_BIT = 6;
    localparam int CC_LIMIT_LSB = 2;
    localparam int BLINK_MODE_BIT = 6;
    localparam int RESUME_OFFSET_BIT = 5;
    localparam int TEMP_REG_LSB = 3;
    localparam int OVPROT_DIS_BIT = 6;
    localparam int SWITCH_MODE_BIT = 5;
    localparam int TIMEOUT_FLAG_BIT = 4;
    localparam int CHARGE_LOCK_BIT = 2;
    localparam int NOBAT_SLOT = 1;
    // saturation points
    localparam logic [3:0] INPUT_CURRENT_MAX = 4'hd;
    localparam logic [5:0] END_VOLTAGE_MAX = 6'h2f;
    // event inputs: [7:0] status one, [15:8] status two, [18:16] status three
    localparam int NEV = 19;
    localparam int NIN = 23;
    localparam logic [NEV-1:0] RISE_EDGE_SET = 19'h3fffe | 19'h00003;
    localparam logic [NEV-1:0] FALL_EDGE_SET = 19'h6103f;
    localparam logic [NEV-1:0] RISE_ONLY_SET = 19'h1ef00;
    // timing
    localparam longint CLK_HZ = 50000000;
    localparam longint NOBAT_DEBOUNCE_MS = 100;
    localparam longint BLINK_HZ = 1;
    localparam longint TIMEOUT_STEP_S = 1800;
    localparam longint NOBAT_DEBOUNCE_CYC = CLK_HZ / 1000 * NOBAT_DEBOUNCE_MS;
    localparam longint BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
    localparam longint TIMEOUT_STEP_CYC = CLK_HZ * TIMEOUT_STEP_S;
    localparam int DEB_W = 24;
    localparam int BLINK_W = 26;
    localparam int STEP_W = 38;
endpackage : pirc_pkg

// >>> src/pirc_regs.sv
// interrupt flag, mask and charger configuration register bank
//
// How it works
// [RQ1] every source has a mask bit; one blocks it, all reset to one
// [RQ2] low-supply and over-temperature flags set when their condition arises
// [RQ3] key, charger, eoc, resume, nobat, trickle, temp, gpio flag both edges
// [RQ4] tick, alarm, boost detect, boost overcurrent, buck low voltage: rising only
// [RQ5] restart flag sets on falling edge of its source only
// [RQ6] flags reset to zero, stay latched, and clear when their register is read
// [RQ7] thermistor no-battery detection, enabled at reset, is debounced by 100 ms
// [RQ8] auto resume restarts charging at resume level; otherwise stay in eoc
// [RQ9] charge enable zero opens battery switch; one runs normal charging
// [RQ10] input current code resets to eight, 13..15 saturate; limiter enable set
// [RQ11] two-bit rail minimum voltage field for trickle and cc current reduction
// [RQ12] six-bit end voltage resets to 35; codes 47 and up saturate
// [RQ13] trickle current resets to code one; eoc current bit halves it
// [RQ14] four-bit constant current limit resets to code zero
// [RQ15] low range bit, set at reset, lowers the constant current limit
// [RQ16] status pin high or blinking at 1 Hz while charging, low otherwise
// [RQ17] resume offset bit chooses smaller or larger level, resets to zero
// [RQ18] two-bit die temperature regulation field resets to code zero
// [RQ19] three-bit rail regulation voltage field resets to code five
// [RQ20] thermistor enable, type and temperature limit bits reset to zero
// [RQ21] mode bit resets to switching charger; separate overvoltage disable bit
// [RQ22] half-hour time-out stops charging, flag reads one, writing zero restarts
// [RQ23] read-only no-battery bit set when missing battery seen after eoc
// [RQ24] lock bit, set only, write-protects voltage, current and config registers
// [RQ25] interrupt output high when any unmasked flag is set
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module pirc_regs
    import pirc_pkg::*;
#(
    parameter logic [DEB_W-1:0] DEBOUNCE_CYCLES = DEB_W'(NOBAT_DEBOUNCE_CYC),
    parameter logic [BLINK_W-1:0] BLINK_CYCLES = BLINK_W'(BLINK_HALF_CYC),
    parameter logic [STEP_W-1:0] TIMEOUT_CYCLES = STEP_W'(TIMEOUT_STEP_CYC)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic low_supply_cond,
    input wire logic over_temp_cond,
    input wire logic key_pressed,
    input wire logic charger_detected,
    input wire logic end_of_charge,
    input wire logic below_resume,
    input wire logic thermistor_open,
    input wire logic trickle_active,
    input wire logic periodic_tick,
    input wire logic boost_load_detect,
    input wire logic boost_overcurrent,
    input wire logic battery_temp_high,
    input wire logic [3:0] buck_low_voltage,
    input wire logic alarm_match,
    input wire logic gpio_level,
    input wire logic gpio_restart,
    input wire logic cv_mode,
    input wire logic cc_mode,
    input wire logic charging_active,
    output logic irq,
    output logic charge_status_pin,
    output logic charge_restart,
    output logic battery_switch_open,
    output logic charge_stopped,
    output logic input_limiter_enable,
    output logic [3:0] input_current_code,
    output logic [1:0] rail_min_code,
    output logic [5:0] end_charge_voltage,
    output logic eoc_current_half,
    output logic constant_current_low_range,
    output logic [3:0] constant_current_limit,
    output logic [1:0] trickle_current_limit,
    output logic resume_voltage_offset,
    output logic [1:0] temp_regulation_code,
    output logic [2:0] rail_regulation_code,
    output logic [2:0] thermistor_supervision_bits,
    output logic overvoltage_protect_disable,
    output logic switching_charger_mode,
    output logic nobat_detected
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [NIN-1:0] s1;
        logic [NIN-1:0] s2;
        logic [NIN-1:0] s3;
        logic [NIN-1:0] stab;
        logic [NEV-1:0] src_q;
        logic [NEV-1:0] flags;
        logic [7:0] mask_one;
        logic [7:0] mask_two;
        logic [2:0] mask_three;
        logic [7:0] ctrl_one;
        logic [7:0] volt_ctrl;
        logic [7:0] curr_ctrl;
        logic [6:0] config_bits;
        logic [2:0] therm_bits;
        logic [5:0] superv_bits;
        logic lock;
        logic nobat_deb;
        logic [DEB_W-1:0] deb_cnt;
        logic [BLINK_W-1:0] blink_cnt;
        logic blink_phase;
        logic [STEP_W-1:0] step_cnt;
        logic [3:0] halfhours;
        logic [7:0] rdata;
    } pirc_state_s;

    pirc_state_s cur;
    pirc_state_s next_cur;

    function automatic logic [3:0] clamp4(input logic [3:0] v, input logic [3:0] top);
        clamp4 = (v > top) ? top : v;
    endfunction : clamp4

    function automatic logic [5:0] clamp6(input logic [5:0] v, input logic [5:0] top);
        clamp6 = (v > top) ? top : v;
    endfunction : clamp6

    ////////////////////////////////////////////////////////////////////////
    logic [NIN-1:0] raw;
    logic [NEV-1:0] src;
    logic [NEV-1:0] rise;
    logic [NEV-1:0] fall;
    logic [NEV-1:0] set_ev;
    logic [NEV-1:0] clr_ev;
    logic [NEV-1:0] mask_all;
    logic therm_stab;
    logic timeout_hit;
    logic timeout_clear;

    assign raw = {charging_active, cc_mode, cv_mode, thermistor_open,
                  gpio_restart, gpio_level, alarm_match,
                  periodic_tick, boost_load_detect, boost_overcurrent, battery_temp_high,
                  buck_low_voltage[3], buck_low_voltage[2], buck_low_voltage[1],
                  buck_low_voltage[0],
                  low_supply_cond, over_temp_cond, key_pressed, charger_detected,
                  end_of_charge, below_resume, 1'b0, trickle_active};
    assign therm_stab = cur.stab[NEV];
    assign mask_all = {cur.mask_three, cur.mask_two, cur.mask_one};

    // nobat slot carries the debounced detection, not the raw pin
    always_comb begin
        src = cur.stab[NEV-1:0];
        src[NOBAT_SLOT] = cur.nobat_deb;
    end

    assign rise = src & ~cur.src_q;
    assign fall = ~src & cur.src_q;
    // see [RQ2] see [RQ3] see [RQ4] see [RQ5]
    assign set_ev = (rise & RISE_EDGE_SET) | (fall & FALL_EDGE_SET);

    // read of a status register clears exactly the flags it returned
    always_comb begin
        clr_ev = '0;
        if (rd && addr == OFS_IRQ_STATUS_ONE) begin
            clr_ev[7:0] = 8'hff;
        end else if (rd && addr == OFS_IRQ_STATUS_TWO) begin
            clr_ev[15:8] = 8'hff;
        end else if (rd && addr == OFS_IRQ_STATUS_THREE) begin
            clr_ev[18:16] = 3'h7;
        end
    end

    assign timeout_hit = (cur.superv_bits[3:0] != 4'h0)
                       && (cur.halfhours >= cur.superv_bits[3:0]);
    assign timeout_clear = wr && addr == OFS_CHARGE_SUPERVISION
                         && !wdata[TIMEOUT_FLAG_BIT];

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_cur = cur;
        // three-stage pin sampling, accepted once stages two and three agree
        next_cur.s1 = raw;
        next_cur.s2 = cur.s1;
        next_cur.s3 = cur.s2;
        for (int i = 0; i < NIN; i++) begin
            if (cur.s2[i] == cur.s3[i]) begin
                next_cur.stab[i] = cur.s3[i];
            end
        end
        next_cur.src_q = src;
        // set wins over a clear in the same cycle
        next_cur.flags = (cur.flags & ~clr_ev) | set_ev; // see [RQ6]

        // thermistor no-battery debounce
        if (!cur.ctrl_one[NOBAT_DET_BIT]) begin // see [RQ7]
            next_cur.nobat_deb = 1'b0;
            next_cur.deb_cnt = '0;
        end else if (therm_stab == cur.nobat_deb) begin
            next_cur.deb_cnt = '0;
        end else if (cur.deb_cnt >= DEBOUNCE_CYCLES - DEB_W'(1)) begin
            next_cur.nobat_deb = therm_stab; // see [RQ7]
            next_cur.deb_cnt = '0;
        end else begin
            next_cur.deb_cnt = cur.deb_cnt + DEB_W'(1);
        end

        // blink divider: free running so the pin phase is steady
        if (cur.blink_cnt >= BLINK_CYCLES - BLINK_W'(1)) begin
            next_cur.blink_cnt = '0;
            next_cur.blink_phase = ~cur.blink_phase; // see [RQ16]
        end else begin
            next_cur.blink_cnt = cur.blink_cnt + BLINK_W'(1);
        end

        // charge time-out, counting only while charging
        if (timeout_clear || cur.superv_bits[3:0] == 4'h0) begin
            next_cur.step_cnt = '0;
            next_cur.halfhours = 4'h0; // see [RQ22]
        end else if (cur.stab[NEV+3] && !timeout_hit) begin
            if (cur.step_cnt >= TIMEOUT_CYCLES - STEP_W'(1)) begin
                next_cur.step_cnt = '0;
                next_cur.halfhours = cur.halfhours + 4'h1;
            end else begin
                next_cur.step_cnt = cur.step_cnt + STEP_W'(1);
            end
        end

        // register writes
        if (wr) begin
            if (addr == OFS_IRQ_MASK_ONE) begin
                next_cur.mask_one = wdata; // see [RQ1]
            end else if (addr == OFS_IRQ_MASK_TWO) begin
                next_cur.mask_two = wdata;
            end else if (addr == OFS_IRQ_MASK_THREE) begin
                next_cur.mask_three = wdata[2:0];
            end else if (addr == OFS_CHARGE_CONTROL_ONE) begin
                next_cur.ctrl_one = wdata;
            end else if (addr == OFS_CHARGE_VOLTAGE_CONTROL && !cur.lock) begin
                next_cur.volt_ctrl = wdata; // see [RQ24]
            end else if (addr == OFS_CHARGE_CURRENT_CONTROL && !cur.lock) begin
                next_cur.curr_ctrl = wdata;
            end else if (addr == OFS_CHARGE_CONFIG && !cur.lock) begin
                next_cur.config_bits = wdata[6:0];
            end else if (addr == OFS_THERMISTOR_SUPERVISION) begin
                next_cur.therm_bits = wdata[2:0]; // see [RQ20]
            end else if (addr == OFS_CHARGE_SUPERVISION) begin
                // bit 4 is the live time-out flag, never stored
                next_cur.superv_bits = {wdata[6:5], wdata[3:0]};
            end else if (addr == OFS_CHARGE_LOCK) begin
                next_cur.lock = cur.lock | wdata[CHARGE_LOCK_BIT]; // see [RQ24]
            end
        end

        // read data, registered for the cycle after the strobe
        next_cur.rdata = 8'h00;
        if (rd) begin
            if (addr == OFS_IRQ_MASK_ONE) begin
                next_cur.rdata = cur.mask_one;
            end else if (addr == OFS_IRQ_MASK_TWO) begin
                next_cur.rdata = cur.mask_two;
            end else if (addr == OFS_IRQ_MASK_THREE) begin
                next_cur.rdata = {5'h00, cur.mask_three};
            end else if (addr == OFS_IRQ_STATUS_ONE) begin
                next_cur.rdata = cur.flags[7:0];
            end else if (addr == OFS_IRQ_STATUS_TWO) begin
                next_cur.rdata = cur.flags[15:8];
            end else if (addr == OFS_IRQ_STATUS_THREE) begin
                next_cur.rdata = {5'h00, cur.flags[18:16]};
            end else if (addr == OFS_CHARGE_CONTROL_ONE) begin
                next_cur.rdata = cur.ctrl_one;
            end else if (addr == OFS_CHARGE_VOLTAGE_CONTROL) begin
                next_cur.rdata = cur.volt_ctrl;
            end else if (addr == OFS_CHARGE_CURRENT_CONTROL) begin
                next_cur.rdata = cur.curr_ctrl;
            end else if (addr == OFS_CHARGE_CONFIG) begin
                next_cur.rdata = {1'b0, cur.config_bits};
            end else if (addr == OFS_THERMISTOR_SUPERVISION) begin
                next_cur.rdata = {5'h00, cur.therm_bits};
            end else if (addr == OFS_CHARGE_SUPERVISION) begin
                next_cur.rdata = {1'b0, cur.superv_bits[5:4], timeout_hit,
                                  cur.superv_bits[3:0]}; // see [RQ22]
            end else if (addr == OFS_CHARGE_STATUS_ONE) begin
                next_cur.rdata = {nobat_detected, cur.stab[12], cur.stab[3],
                                  cur.stab[NEV+1], cur.stab[0], cur.stab[2],
                                  cur.stab[NEV+2], cur.stab[4]}; // see [RQ23]
            end else if (addr == OFS_CHARGE_LOCK) begin
                next_cur.rdata = {5'h00, cur.lock, 2'b00};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cur <= '0;
            cur.mask_one <= RST_IRQ_MASK_ONE; // see [RQ1]
            cur.mask_two <= RST_IRQ_MASK_TWO;
            cur.mask_three <= RST_IRQ_MASK_THREE;
            cur.ctrl_one <= RST_CHARGE_CONTROL_ONE; // see [RQ7] see [RQ8] see [RQ10]
            cur.volt_ctrl <= RST_CHARGE_VOLTAGE_CONTROL; // see [RQ11] see [RQ12]
            cur.curr_ctrl <= RST_CHARGE_CURRENT_CONTROL; // see [RQ13] see [RQ14]
            cur.config_bits <= RST_CHARGE_CONFIG; // see [RQ17] see [RQ18] see [RQ19]
            cur.therm_bits <= RST_THERMISTOR_SUPERVISION;
            cur.superv_bits <= RST_CHARGE_SUPERVISION; // see [RQ21]
        end else begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign rdata = cur.rdata;
    assign irq = |(cur.flags & ~mask_all); // see [RQ25]
    // see [RQ16]
    assign charge_status_pin = cur.stab[NEV+3]
                             & (cur.config_bits[BLINK_MODE_BIT] ? cur.blink_phase : 1'b1);
    // see [RQ8]
    assign charge_restart = cur.ctrl_one[AUTO_RESUME_BIT] & cur.stab[3] & cur.stab[2];
    assign battery_switch_open = ~cur.ctrl_one[CHARGE_ENABLE_BIT]; // see [RQ9]
    assign charge_stopped = timeout_hit; // see [RQ22]
    assign input_limiter_enable = cur.ctrl_one[LIMITER_ENABLE_BIT];
    // see [RQ10]
    assign input_current_code = clamp4(cur.ctrl_one[INPUT_CURRENT_LSB +: 4], INPUT_CURRENT_MAX);
    assign rail_min_code = cur.volt_ctrl[RAIL_MIN_LSB +: 2]; // see [RQ11]
    assign end_charge_voltage = clamp6(cur.volt_ctrl[5:0], END_VOLTAGE_MAX); // see [RQ12]
    assign eoc_current_half = cur.curr_ctrl[EOC_CURRENT_HALF_BIT]; // see [RQ13]
    assign constant_current_low_range = cur.curr_ctrl[CC_LOW_RANGE_BIT]; // see [RQ15]
    assign constant_current_limit = cur.curr_ctrl[CC_LIMIT_LSB +: 4]; // see [RQ14]
    assign trickle_current_limit = cur.curr_ctrl[1:0];
    assign resume_voltage_offset = cur.config_bits[RESUME_OFFSET_BIT]; // see [RQ17]
    assign temp_regulation_code = cur.config_bits[TEMP_REG_LSB +: 2]; // see [RQ18]
    assign rail_regulation_code = cur.config_bits[2:0]; // see [RQ19]
    assign thermistor_supervision_bits = cur.therm_bits;
    assign overvoltage_protect_disable = cur.superv_bits[OVPROT_DIS_BIT - 1]; // see [RQ21]
    assign switching_charger_mode = cur.superv_bits[SWITCH_MODE_BIT - 1];
    // no-battery only reported once end of charge has been reached
    assign nobat_detected = cur.nobat_deb & cur.stab[3]; // see [RQ23]

endmodule : pirc_regs
`default_nettype wire

// >>> verif/pirc_regs_monitor.sv
// port-level assertions for the interrupt and charger register bank
`timescale 1ns/10ps
`default_nettype none
module pirc_regs_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic irq,
    input wire logic end_of_charge,
    input wire logic charging_active,
    input wire logic charge_status_pin,
    input wire logic charge_restart,
    input wire logic battery_switch_open,
    input wire logic input_limiter_enable,
    input wire logic [3:0] input_current_code,
    input wire logic [5:0] end_charge_voltage
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    a_reset_irq_quiet: assert property ($rose(rst_n) |-> !irq && rdata == 8'h00)
        else $error("irq or read data active right after reset");
    a_reset_limits: assert property ($rose(rst_n) |-> input_current_code == 4'h8
        && input_limiter_enable) else $error("input limit fields wrong after reset");
    a_reset_end_volt: assert property ($rose(rst_n) |-> end_charge_voltage == 6'h23)
        else $error("end voltage field wrong after reset");
    a_current_clamp: assert property (wr && addr == 8'h80 |=> input_current_code ==
        (($past(wdata[4:1]) > 4'hd) ? 4'hd : $past(wdata[4:1])))
        else $error("input current code not clamped to the written value");
    a_end_volt_range: assert property (end_charge_voltage <= 6'h2f)
        else $error("end voltage code above saturation");
    a_switch_follows: assert property (wr && addr == 8'h80 |=>
        battery_switch_open == !$past(wdata[5]) && input_limiter_enable == $past(wdata[0]))
        else $error("switch or limiter enable not following write");
    a_mask_readback: assert property (wr && addr == 8'h74 ##2 rd && addr == 8'h74 |=>
        rdata == $past(wdata, 3)) else $error("mask register readback wrong");
    a_read_idle_zero: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    a_pin_low_idle: assert property (!charging_active [*6] |-> !charge_status_pin)
        else $error("status pin high while not charging");
    a_restart_needs_eoc: assert property (!end_of_charge [*6] |-> !charge_restart)
        else $error("charge restart outside end of charge");
endmodule : pirc_regs_monitor
bind pirc_regs pirc_regs_monitor u_mon (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .end_of_charge(end_of_charge),
    .charging_active(charging_active), .charge_status_pin(charge_status_pin),
    .charge_restart(charge_restart), .battery_switch_open(battery_switch_open),
    .input_limiter_enable(input_limiter_enable), .input_current_code(input_current_code),
    .end_charge_voltage(end_charge_voltage));
`default_nettype wire

// >>> verif/pirc_regs_test.sv
// self-checking bench for the interrupt and charger register bank
`timescale 1ns/10ps
`default_nettype none
module pirc_regs_test;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, charging_active = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [18:0] ev = '0;
    logic irq, sw_open, stopped, lim_en, eoc_half, cc_low, resume_ofs, ovp_dis, sw_mode;
    logic [3:0] cur_code, cc_lim;
    logic [1:0] rail_min, trickle, temp_reg;
    logic [2:0] rail_reg, ntc_bits;
    logic [5:0] eoc_volt;
    int fails = 0, tests_run = 0;
    integer seed = 32'h11451457;
    // ev bit i is status register 0x77 + i/8, bit i%8
    localparam logic [18:0] RISE_SET = 19'h3ffff;
    localparam logic [18:0] FALL_SET = 19'h6103f;
    // time-out flag reads zero out of reset
    localparam logic [7:0] RST_ADR [12] = '{8'h74, 8'h75, 8'h76, 8'h77, 8'h78, 8'h79,
        8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85};
    localparam logic [7:0] RST_VAL [12] = '{8'hff, 8'hff, 8'h07, 8'h00, 8'h00, 8'h00,
        8'hd1, 8'h63, 8'h41, 8'h05, 8'h00, 8'h20};
    always #10 clk = ~clk;
    pirc_regs #(.DEBOUNCE_CYCLES(24'd8), .BLINK_CYCLES(26'd4), .TIMEOUT_CYCLES(38'd16)) dut (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .low_supply_cond(ev[7]), .over_temp_cond(ev[6]), .key_pressed(ev[5]),
        .charger_detected(ev[4]), .end_of_charge(ev[3]), .below_resume(ev[2]),
        .thermistor_open(ev[1]), .trickle_active(ev[0]), .periodic_tick(ev[15]),
        .boost_load_detect(ev[14]), .boost_overcurrent(ev[13]), .battery_temp_high(ev[12]),
        .buck_low_voltage(ev[11:8]), .alarm_match(ev[16]), .gpio_level(ev[17]),
        .gpio_restart(ev[18]), .cv_mode(1'b0), .cc_mode(1'b0),
        .charging_active(charging_active), .irq(irq), .charge_status_pin(),
        .charge_restart(), .battery_switch_open(sw_open), .charge_stopped(stopped),
        .input_limiter_enable(lim_en), .input_current_code(cur_code), .rail_min_code(rail_min),
        .end_charge_voltage(eoc_volt), .eoc_current_half(eoc_half),
        .constant_current_low_range(cc_low), .constant_current_limit(cc_lim),
        .trickle_current_limit(trickle), .resume_voltage_offset(resume_ofs),
        .temp_regulation_code(temp_reg), .rail_regulation_code(rail_reg),
        .thermistor_supervision_bits(ntc_bits), .overvoltage_protect_disable(ovp_dis),
        .switching_charger_mode(sw_mode), .nobat_detected());
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // an idle cycle after each access keeps a strobe from being driven twice in one step
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, exp);
        @(posedge clk);
    endtask : rd_chk
    function automatic logic [7:0] exp_fields(input logic [7:0] a, input logic [7:0] w);
        case (a)
            8'h80: return {2'h0, !w[5], (w[4:1] > 4'hd) ? 4'hd : w[4:1], w[0]};
            8'h81: return {w[7:6], (w[5:0] > 6'h2f) ? 6'h2f : w[5:0]};
            8'h83: return {2'h0, w[5:0]};
            8'h84: return {5'h0, w[2:0]};
            default: return w;
        endcase
    endfunction : exp_fields
    function automatic logic [7:0] got_fields(input logic [7:0] a);
        case (a)
            8'h80: return {2'h0, sw_open, cur_code, lim_en};
            8'h81: return {rail_min, eoc_volt};
            8'h83: return {2'h0, resume_ofs, temp_reg, rail_reg};
            8'h84: return {5'h0, ntc_bits};
            default: return {eoc_half, cc_low, cc_lim, trickle};
        endcase
    endfunction : got_fields
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////////////
    initial begin : watchdog
        repeat (20000) @(posedge clk);
        fails++;
        give_verdict;
    end
    initial begin : main
        logic [7:0] w;
        logic [7:0] a;
        logic e;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        foreach (RST_ADR[i]) rd_chk(RST_ADR[i], RST_VAL[i]);
        for (int n = 0; n < 8; n++) begin
            for (int k = 0; k < 5; k++) begin
                a = 8'h80 + 8'(k);
                w = (n == 0) ? 8'hff : (n == 1) ? 8'h5a : 8'($random(seed));
                wr_reg(a, w);
                chk(got_fields(a), exp_fields(a, w));
                rd_chk(a, w & ((k == 3) ? 8'h7f : (k == 4) ? 8'h07 : 8'hff));
            end
        end
        // charge time-out at its shortest setting
        wr_reg(8'h85, 8'h61);
        charging_active <= 1'b1;
        chk({6'h0, ovp_dis, sw_mode}, 8'h03);
        repeat (10) @(posedge clk);
        chk({7'h0, stopped}, 8'h00);
        for (int n = 0; n < 60 && stopped !== 1'b1; n++) @(posedge clk);
        chk({7'h0, stopped}, 8'h01);
        rd_chk(8'h85, 8'h71);
        wr_reg(8'h85, 8'h61);
        chk({7'h0, stopped}, 8'h00);
        charging_active <= 1'b0;
        wr_reg(8'h85, 8'h20);
        // every event source, rising then falling, all unmasked
        wr_reg(8'h80, 8'hd1);
        for (int k = 0; k < 3; k++) wr_reg(8'h74 + 8'(k), 8'h00);
        for (int i = 0; i < 19; i++) begin
            for (int lvl = 1; lvl >= 0; lvl--) begin
                ev[i] <= lvl[0];
                repeat (20) @(posedge clk);
                e = lvl[0] ? RISE_SET[i] : FALL_SET[i];
                @(negedge clk);
                chk({7'h0, irq}, {7'h0, e});
                @(posedge clk);
                rd_chk(8'h77 + 8'(i / 8), 8'({7'h0, e} << (i % 8)));
                if (i == 12 && lvl == 1) rd_chk(8'h86, 8'h40);
            end
        end
        // masked flag still latches but keeps irq low
        wr_reg(8'h74, 8'hff);
        rd_chk(8'h74, 8'hff);
        ev[5] <= 1'b1;
        repeat (20) @(posedge clk);
        chk({7'h0, irq}, 8'h00);
        rd_chk(8'h77, 8'h20);
        rd_chk(8'h77, 8'h00);
        // lock keeps charger voltage register against a later write
        wr_reg(8'h81, 8'h2a);
        wr_reg(8'h8e, 8'h04);
        wr_reg(8'h81, 8'h00);
        rd_chk(8'h81, 8'h2a);
        wr_reg(8'h00, 8'h55);
        rd_chk(8'h00, 8'h00);
        give_verdict;
    end
endmodule : pirc_regs_test
`default_nettype wire
